/* hw/sce_top.sv */
// screen contamination evaluator with register port and indicator outputs
`timescale 1ns/10ps
module sce_top
    import sce_pkg::*;
(
    // clock, reset, enable
    input  wire logic                  i_core_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_core_ce,
    // sector limit flags from the measuring system
    input  wire logic [SCE_NSECT-1:0]  i_warn_sect,
    input  wire logic [SCE_NSECT-1:0]  i_err_sect,
    // register port
    input  wire logic [SCE_ADDR_W-1:0] i_addr,
    input  wire logic [SCE_DATA_W-1:0] i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [SCE_DATA_W-1:0] o_rdata,
    // status indicators
    output logic                       o_ind_warn,
    output logic                       o_ind_err
);

    sce_eval_if ev_if ();

    logic [2:0] strat_q;
    logic [5:0] warn_sync_q;
    logic [5:0] err_sync_q;
    logic       warn_seen_q;
    logic       warn_seen_d;
    logic       err_seen_q;
    logic       err_seen_d;
    logic       wr_stat;
    logic [2:0] cnt_w;
    logic [2:0] cnt_e;

    assign ev_if.strat      = strat_q;
    assign ev_if.warn_flags = warn_sync_q;
    assign ev_if.err_flags  = err_sync_q;
    assign wr_stat          = i_core_ce && i_wr && (i_addr == SCE_OFF_STAT);
    assign cnt_w            = sce_count(warn_sync_q);
    assign cnt_e            = sce_count(err_sync_q);

    sce_eval u_eval (
        .bus (ev_if.ev)
    );

    // strategy register
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strat_q <= SCE_STRAT_RST;
        end else if (i_core_ce && i_wr && i_addr == SCE_OFF_CTRL) begin
            strat_q <= i_wdata[2:0];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            warn_sync_q <= 6'h00;
            err_sync_q  <= 6'h00;
        end else if (i_core_ce) begin
            warn_sync_q <= i_warn_sect;
            err_sync_q  <= i_err_sect;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_ind_warn <= 1'h0;
            o_ind_err  <= 1'h0;
        end else if (i_core_ce) begin
            o_ind_warn <= ev_if.warn;
            o_ind_err  <= ev_if.err;
        end
    end

    // sticky seen bits, write one clears, a new event wins
    always_comb begin
        warn_seen_d = warn_seen_q;
        err_seen_d  = err_seen_q;
        if (wr_stat && i_wdata[SCE_STAT_WSEEN]) begin
            warn_seen_d = 1'h0;
        end
        if (wr_stat && i_wdata[SCE_STAT_ESEEN]) begin
            err_seen_d = 1'h0;
        end
        if (o_ind_warn) begin
            warn_seen_d = 1'h1;
        end
        if (o_ind_err) begin
            err_seen_d = 1'h1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            warn_seen_q <= 1'h0;
            err_seen_q  <= 1'h0;
        end else if (i_core_ce) begin
            warn_seen_q <= warn_seen_d;
            err_seen_q  <= err_seen_d;
        end
    end

    // read data stand for one enabled cycle only, held while the enable is low
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_core_ce) begin
            o_rdata <= 32'h0000_0000;
            if (i_rd) begin
                if (i_addr == SCE_OFF_CTRL) begin
                    o_rdata[2:0] <= strat_q;
                end else if (i_addr == SCE_OFF_STAT) begin
                    o_rdata[SCE_STAT_WARN]  <= o_ind_warn;
                    o_rdata[SCE_STAT_ERR]   <= o_ind_err;
                    o_rdata[SCE_STAT_WSEEN] <= warn_seen_q;
                    o_rdata[SCE_STAT_ESEEN] <= err_seen_q;
                end else if (i_addr == SCE_OFF_FLAG) begin
                    o_rdata[SCE_FLAG_WARN +: 6] <= warn_sync_q;
                    o_rdata[SCE_FLAG_ERR +: 6]  <= err_sync_q;
                end
            end
        end
    end

    // ---------------- checks beside the logic ----------------

    property p_deact;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_DEACT) |=> (!o_ind_warn && !o_ind_err);
    endproperty
    a_deact: assert property (p_deact)
        else $error("deactivated strategy drove an indicator");

    property p_high_warn;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_HIGH_AVAIL) |=> (o_ind_warn == $past(&warn_sync_q));
    endproperty
    a_high_warn: assert property (p_high_warn)
        else $error("high availability warning wrong");

    property p_high_err;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_HIGH_AVAIL) |=> (o_ind_err == $past(&err_sync_q));
    endproperty
    a_high_err: assert property (p_high_err)
        else $error("high availability error wrong");

    property p_avail;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_AVAIL) |=>
            (o_ind_warn == $past((&warn_sync_q[2:0]) || (&warn_sync_q[5:3]))) &&
            (o_ind_err == $past((&err_sync_q[2:0]) || (&err_sync_q[5:3])));
    endproperty
    a_avail: assert property (p_avail)
        else $error("available strategy half evaluation wrong");

    property p_semi_none;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_SEMI && cnt_e == 3'h0 && cnt_w <= 3'h1)
            |=> (!o_ind_warn && !o_ind_err);
    endproperty
    a_semi_none: assert property (p_semi_none)
        else $error("semi-sensitive clean screen flagged");

    property p_semi_warn;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_SEMI && cnt_e == 3'h1 && cnt_w >= 3'h2)
            |=> (o_ind_warn && !o_ind_err);
    endproperty
    a_semi_warn: assert property (p_semi_warn)
        else $error("semi-sensitive warning missing");

    property p_semi_err;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_SEMI && cnt_e >= 3'h2) |=> o_ind_err;
    endproperty
    a_semi_err: assert property (p_semi_err)
        else $error("semi-sensitive error missing");

    property p_semi_other;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_SEMI && cnt_e == 3'h1 && cnt_w <= 3'h1)
            |=> (!o_ind_warn && !o_ind_err);
    endproperty
    a_semi_other: assert property (p_semi_other)
        else $error("semi-sensitive unmatched case flagged");

    property p_sens;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_SENS) |=>
            (o_ind_warn == $past(|warn_sync_q)) && (o_ind_err == $past(|err_sync_q));
    endproperty
    a_sens: assert property (p_sens)
        else $error("sensitive strategy wrong");

    property p_err_source;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && err_sync_q == 6'h00) |=> !o_ind_err;
    endproperty
    a_err_source: assert property (p_err_source)
        else $error("error raised with no sector at error limit");

    property p_latency;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_SENS) [*2] |=> (o_ind_err == $past(|i_err_sect, 2));
    endproperty
    a_latency: assert property (p_latency)
        else $error("indicator not two cycles behind the flags");

    property p_freeze;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !i_core_ce |=> ($stable(o_ind_warn) && $stable(o_ind_err) && $stable(strat_q));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while enable was low");

    property p_ind_route;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && i_rd && i_addr == SCE_OFF_STAT) |=>
            (o_rdata[SCE_STAT_WARN] == $past(o_ind_warn)) &&
            (o_rdata[SCE_STAT_ERR] == $past(o_ind_err));
    endproperty
    a_ind_route: assert property (p_ind_route)
        else $error("status read disagrees with indicators");

    property p_ctrl_read;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && i_rd && i_addr == SCE_OFF_CTRL) |=>
            (o_rdata == {29'h0000_0000, $past(strat_q)});
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("strategy readback wrong");

    property p_rd_idle;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && !i_rd) |=> (o_rdata == 32'h0000_0000);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside the read answer cycle");

    property p_seen_set;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && o_ind_warn) |=> warn_seen_q;
    endproperty
    a_seen_set: assert property (p_seen_set)
        else $error("warning event lost against clear");

    property p_semi_err_only;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q == SCE_SEMI && cnt_e >= 3'h2) |=> !o_ind_warn;
    endproperty
    a_semi_err_only: assert property (p_semi_err_only)
        else $error("semi-sensitive error also raised the warning");

    property p_warn_source;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && warn_sync_q == 6'h00) |=> !o_ind_warn;
    endproperty
    a_warn_source: assert property (p_warn_source)
        else $error("warning raised with no sector at warning limit");

    property p_spare_codes;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && strat_q > SCE_SENS) |=> (!o_ind_warn && !o_ind_err);
    endproperty
    a_spare_codes: assert property (p_spare_codes)
        else $error("unused strategy code drove an indicator");

    property p_sync_take;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && !i_sys_rst) |=>
            (warn_sync_q == $past(i_warn_sect)) && (err_sync_q == $past(i_err_sect));
    endproperty
    a_sync_take: assert property (p_sync_take)
        else $error("sector flags not taken in");

    property p_strat_write;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && !i_sys_rst && i_wr && i_addr == SCE_OFF_CTRL) |=>
            (strat_q == $past(i_wdata[2:0]));
    endproperty
    a_strat_write: assert property (p_strat_write)
        else $error("strategy write not taken");

    property p_flag_read;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && i_rd && i_addr == SCE_OFF_FLAG) |=>
            (o_rdata == {18'h0_0000, $past(err_sync_q), 2'h0, $past(warn_sync_q)});
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("flag readback disagrees with the flag stage");

    property p_stat_read;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && i_rd && i_addr == SCE_OFF_STAT) |=>
            (o_rdata[SCE_STAT_WSEEN] == $past(warn_seen_q)) &&
            (o_rdata[SCE_STAT_ESEEN] == $past(err_seen_q)) &&
            (o_rdata[31:4] == 28'h000_0000);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status sticky bits read back wrong");

    property p_err_seen_set;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_core_ce && o_ind_err) |=> err_seen_q;
    endproperty
    a_err_seen_set: assert property (p_err_seen_set)
        else $error("error event lost against clear");

    property p_seen_clear;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (wr_stat && i_wdata[SCE_STAT_WSEEN] && !o_ind_warn) |=> !warn_seen_q;
    endproperty
    a_seen_clear: assert property (p_seen_clear)
        else $error("warning seen bit not cleared by write one");

    property p_freeze_flags;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !i_core_ce |=>
            ($stable(o_rdata) && $stable(warn_sync_q) && $stable(err_sync_q) &&
             $stable(warn_seen_q));
    endproperty
    a_freeze_flags: assert property (p_freeze_flags)
        else $error("flag stage or read data moved while enable was low");

    property p_reset_clear;
        @(posedge i_core_clk)
        (i_sys_rst && $past(i_sys_rst)) |-> (!o_ind_warn && !o_ind_err && o_rdata == 32'h0000_0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset left an output active");

    c_semi_warn: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        strat_q == SCE_SEMI && o_ind_warn);
    c_avail_err: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        strat_q == SCE_AVAIL && o_ind_err);
    c_high_err: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        strat_q == SCE_HIGH_AVAIL && o_ind_err);
    c_seen_clr: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        warn_seen_q ##1 !warn_seen_q);
    c_semi_err: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        strat_q == SCE_SEMI && o_ind_err);

endmodule

/* hw/sce_pkg.sv */
// constants, types and helpers of the screen contamination evaluator
package sce_pkg;

    // sector layout
    localparam int unsigned SCE_NSECT    = 6;
    localparam int unsigned SCE_GRP      = 3;
    localparam int unsigned SCE_CNT_W    = 3;

    // register bus
    localparam int unsigned SCE_ADDR_W   = 8;
    localparam int unsigned SCE_DATA_W   = 32;
    localparam logic [7:0]  SCE_OFF_CTRL = 8'h00;
    localparam logic [7:0]  SCE_OFF_STAT = 8'h04;
    localparam logic [7:0]  SCE_OFF_FLAG = 8'h08;

    // field positions
    localparam int unsigned SCE_STAT_WARN  = 0;
    localparam int unsigned SCE_STAT_ERR   = 1;
    localparam int unsigned SCE_STAT_WSEEN = 2;
    localparam int unsigned SCE_STAT_ESEEN = 3;
    localparam int unsigned SCE_FLAG_WARN  = 0;
    localparam int unsigned SCE_FLAG_ERR   = 8;

    // reset values
    localparam logic [2:0]  SCE_STRAT_RST  = 3'h0;

    typedef enum logic [2:0] {
        SCE_DEACT,
        SCE_HIGH_AVAIL,
        SCE_AVAIL,
        SCE_SEMI,
        SCE_SENS
    } sce_strat_e;

    // number of sectors that reached a limit
    function automatic logic [2:0] sce_count(input logic [5:0] f);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < SCE_NSECT; i++) begin
            n = n + {2'h0, f[i]};
        end
        return n;
    endfunction

endpackage

/* hw/sce_eval_if.sv */
// carrier between the register side and the strategy evaluator
`timescale 1ns/10ps
interface sce_eval_if;
    logic [2:0] strat;
    logic [5:0] warn_flags;
    logic [5:0] err_flags;
    logic       warn;
    logic       err;

    modport ctl (output strat, output warn_flags, output err_flags, input warn, input err);
    modport ev  (input strat, input warn_flags, input err_flags, output warn, output err);
endinterface

/* hw/sce_eval.sv */
// combinational strategy evaluator for the six screen sectors
`timescale 1ns/10ps
module sce_eval
    import sce_pkg::*;
(
    // flags in, decision out
    sce_eval_if.ev bus
);

    logic [2:0] n_warn;
    logic [2:0] n_err;

    always_comb begin
        n_warn   = sce_count(bus.warn_flags);
        n_err    = sce_count(bus.err_flags);
        bus.warn = 1'h0;
        bus.err  = 1'h0;
        case (bus.strat)
            SCE_HIGH_AVAIL: begin
                bus.warn = &bus.warn_flags;
                bus.err  = &bus.err_flags;
            end
            SCE_AVAIL: begin
                bus.warn = (&bus.warn_flags[2:0]) | (&bus.warn_flags[5:3]);
                bus.err  = (&bus.err_flags[2:0]) | (&bus.err_flags[5:3]);
            end
            SCE_SEMI: begin
                if (n_err >= 3'h2) begin
                    bus.err = 1'h1;
                end else if (n_err == 3'h1 && n_warn >= 3'h2) begin
                    bus.warn = 1'h1;
                end
            end
            // warning and error from own limits
            SCE_SENS: begin
                bus.warn = |bus.warn_flags;
                bus.err  = |bus.err_flags;
            end
            default: begin
                bus.warn = 1'h0;
                bus.err  = 1'h0;
            end
        endcase
    end

endmodule

/* testbench/sce_meas_model.sv */
// behavioural model of the outside contamination measuring system
`timescale 1ns/10ps
module sce_meas_model (
    // clock
    input  wire logic       i_core_clk,
    // contamination level asked for by the bench
    input  wire logic [5:0] i_warn_lvl,
    input  wire logic [5:0] i_err_lvl,
    // sector limit flags towards the evaluator
    output logic      [5:0] o_warn_sect,
    output logic      [5:0] o_err_sect
);
    // continuous per-sector flags
    // a sector past its error limit is also past its lower warning limit
    always_ff @(posedge i_core_clk) begin
        o_warn_sect <= i_warn_lvl | i_err_lvl;
        o_err_sect  <= i_err_lvl;
    end
endmodule

/* testbench/screen_contamination_evaluator_tb_top.sv */
// self-checking bench of the screen contamination evaluator
`timescale 1ns/10ps
module screen_contamination_evaluator_tb_top;
    import sce_pkg::*;
    logic        i_core_clk, i_sys_rst, i_core_ce, i_wr, i_rd;
    logic [5:0]  lvl_w, lvl_e, i_warn_sect, i_err_sect;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic        o_ind_warn, o_ind_err;
    int          n_fail, samples_checked;
    localparam logic [5:0] PW [10] = '{6'h00, 6'h3F, 6'h07, 6'h00, 6'h00,
                                       6'h01, 6'h03, 6'h01, 6'h00, 6'h1B};
    localparam logic [5:0] PE [10] = '{6'h00, 6'h00, 6'h00, 6'h38, 6'h3F,
                                       6'h00, 6'h01, 6'h01, 6'h05, 6'h00};

    sce_meas_model u_sce_meas_model (.i_core_clk(i_core_clk), .i_warn_lvl(lvl_w),
        .i_err_lvl(lvl_e), .o_warn_sect(i_warn_sect), .o_err_sect(i_err_sect));
    sce_top u_sce_top (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_core_ce(i_core_ce),
        .i_warn_sect(i_warn_sect), .i_err_sect(i_err_sect), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_ind_warn(o_ind_warn), .o_ind_err(o_ind_err));

    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    function automatic int cnt(input logic [5:0] f);
        int n;
        n = 0;
        for (int i = 0; i < 6; i++) n += f[i];
        return n;
    endfunction

    // expected {err, warn} for a strategy and effective flags
    function automatic logic [1:0] expect_ind(input int s, input logic [5:0] w, e);
        case (s)
            1: return {&e, &w};
            2: return {&e[2:0] | &e[5:3], &w[2:0] | &w[5:3]};
            3: return {cnt(e) >= 2, cnt(e) == 1 && cnt(w) >= 2};
            4: return {|e, |w};
            default: return 2'b00;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd   <= 1'b0;
        #1 chk(o_rdata, exp, "read data");
        @(posedge i_core_clk);
        #1 chk(o_rdata, 32'h0000_0000, "read data after its cycle");
    endtask

    task automatic set_lvl(input logic [5:0] w, e);
        @(posedge i_core_clk);
        lvl_w <= w;
        lvl_e <= e;
        repeat (5) @(posedge i_core_clk);
        #1;
    endtask

    task automatic chk_ind(input logic [1:0] exp);
        chk({30'h0, o_ind_err, o_ind_warn}, {30'h0, exp}, "indicators");
    endtask

    task automatic final_report;
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(20 * 20000);
        n_fail++;
        final_report();
    end

    initial begin
        logic [5:0] ew;
        n_fail = 0;
        samples_checked = 0;
        i_sys_rst = 1'b1;
        i_core_ce = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        lvl_w = 6'h00;
        lvl_e = 6'h00;
        repeat (12) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        #1 chk_ind(2'b00);
        rd(SCE_OFF_CTRL, 32'h0000_0000);
        $display("test reset done");
        for (int s = 0; s < 8; s++) begin
            wr(SCE_OFF_CTRL, s);
            rd(SCE_OFF_CTRL, s);
            for (int p = 0; p < 10; p++) begin
                ew = PW[p] | PE[p];
                set_lvl(PW[p], PE[p]);
                chk_ind(expect_ind(s, ew, PE[p]));
                if (s == 0) rd(SCE_OFF_FLAG, {18'h0, PE[p], 2'h0, ew});
            end
        end
        $display("test strategies done");
        wr(SCE_OFF_CTRL, 32'h4);
        set_lvl(6'h01, 6'h01);
        rd(SCE_OFF_STAT, 32'h0000_000F);
        wr(SCE_OFF_STAT, 32'h0000_000C);
        rd(SCE_OFF_STAT, 32'h0000_000F);
        set_lvl(6'h00, 6'h00);
        rd(SCE_OFF_STAT, 32'h0000_000C);
        wr(SCE_OFF_STAT, 32'h0000_000C);
        rd(SCE_OFF_STAT, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0001);
        rd(SCE_OFF_CTRL, 32'h0000_0004);
        $display("test status done");
        set_lvl(6'h01, 6'h01);
        @(posedge i_core_clk);
        i_core_ce <= 1'b0;
        set_lvl(6'h00, 6'h00);
        chk_ind(2'b11);
        @(posedge i_core_clk);
        i_core_ce <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        #1 chk_ind(2'b00);
        $display("test enable done");
        set_lvl(6'h00, 6'h01);
        chk_ind(2'b11);
        @(posedge i_core_clk);
        i_sys_rst <= 1'b1;
        #2 chk_ind(2'b00);
        repeat (2) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        #1 chk_ind(2'b00);
        rd(SCE_OFF_CTRL, 32'h0000_0000);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
